// *** alarm_pkg.sv ***
// Constants, register map and alarm type codes for the alarm evaluator.
// Assumes one 20 MHz clock and a plain address/strobe register port.
package alarm_pkg;
    localparam int          NCH            = 3;
    localparam int          AW             = 8;
    localparam int          DW             = 32;
    localparam int          VW             = 16;
    localparam int          XW             = 18;
    localparam int          TW             = 5;
    localparam int          DLW            = 10;
    localparam int          RAW_W          = 12;
    localparam int          RAW_SHIFT      = 12;

    // Timing
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          SEC_TIME_NS    = 1000000000;
    localparam int          SEC_CYCLES     = SEC_TIME_NS / CLK_PERIOD_NS;
    localparam int          CNT_W          = 25;

    // Register offsets (byte addresses)
    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;
    localparam logic [7:0]  SCALE_LO_OFS   = 8'h08;
    localparam logic [7:0]  SCALE_HI_OFS   = 8'h0c;
    localparam logic [7:0]  CH_BASE_OFS    = 8'h20;
    localparam logic [7:0]  CH_STRIDE      = 8'h20;
    localparam logic [4:0]  CH_TYPE_OFS    = 5'h00;
    localparam logic [4:0]  CH_TRIP_OFS    = 5'h04;
    localparam logic [4:0]  CH_UPPER_OFS   = 5'h08;
    localparam logic [4:0]  CH_LOWER_OFS   = 5'h0c;
    localparam logic [4:0]  CH_HYS_OFS     = 5'h10;
    localparam logic [4:0]  CH_ON_DLY_OFS  = 5'h14;
    localparam logic [4:0]  CH_OFF_DLY_OFS = 5'h18;

    // Control register fields
    localparam int          CTRL_HEATCOOL  = 0;
    localparam int          CTRL_REMOTE    = 1;
    localparam int          CTRL_HTR_OPT   = 2;
    localparam int          CTRL_CH1_ALARM = 3;
    localparam int          CTRL_ANALOG    = 4;
    localparam int          CTRL_DP_LSB    = 5;
    localparam int          CTRL_W         = 7;
    localparam logic [6:0]  CTRL_RST       = 7'h00;

    // Status register fields
    localparam int          ST_OUT_LSB     = 0;
    localparam int          ST_RAW_LSB     = 3;
    localparam int          ST_SBY_LSB     = 6;
    localparam int          ST_HTR         = 9;

    // Limits and reset values
    localparam logic signed [15:0] SPAN_MIN = 16'shf831;
    localparam logic signed [15:0] SPAN_MAX = 16'sh270f;
    localparam logic [15:0] HYS_MIN        = 16'h0001;
    localparam logic [15:0] HYS_MAX        = 16'h270f;
    localparam logic [15:0] HYS_RST        = 16'h0001;
    localparam logic [9:0]  DLY_MAX        = 10'h3e7;
    localparam logic signed [15:0] SCALE_LO_RST = 16'sh0000;
    localparam logic signed [15:0] SCALE_HI_RST = 16'sh0064;

    typedef enum logic [4:0] {
        AT_NONE      = 5'h00,
        AT_DEV_BAND  = 5'h01,
        AT_DEV_HI    = 5'h02,
        AT_DEV_LO    = 5'h03,
        AT_RANGE     = 5'h04,
        AT_SB_BAND   = 5'h05,
        AT_SB_HI     = 5'h06,
        AT_SB_LO     = 5'h07,
        AT_ABS_HI    = 5'h08,
        AT_ABS_LO    = 5'h09,
        AT_SB_ABS_HI = 5'h0a,
        AT_SB_ABS_LO = 5'h0b,
        AT_LOOP      = 5'h0c,
        AT_RATE      = 5'h0d,
        AT_SP_HI     = 5'h0e,
        AT_SP_LO     = 5'h0f,
        AT_MV_HI     = 5'h10,
        AT_MV_LO     = 5'h11,
        AT_RSP_HI    = 5'h12,
        AT_RSP_LO    = 5'h13
    } alarm_type_t;

    localparam logic [4:0]  TYPE_RST       = 5'h02;
    localparam logic [4:0]  TYPE_LAST      = 5'h13;
endpackage

// *** alarm_delay_if.sv ***
// Carrier between the evaluator and one ON/OFF delay timer.
// Assumes both ends share the evaluator clock.
`timescale 1ns/10ps
interface alarm_delay_if;
    logic       cond;
    logic [9:0] on_delay;
    logic [9:0] off_delay;
    logic       out;
    modport evaluator (output cond, output on_delay, output off_delay, input out);
    modport timer     (input cond, input on_delay, input off_delay, output out);
endinterface

// *** alarm_delay_timer.sv ***
// ON/OFF delay for one alarm channel, counted in whole seconds.
// Assumes a one-cycle seconds tick from the evaluator's divider.
`timescale 1ns/10ps
module alarm_delay_timer (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    input  wire logic   sec_tick,
    alarm_delay_if.timer dly
);
    import alarm_pkg::*;

    logic [DLW-1:0] count_reg;
    logic           out_reg;
    logic [DLW-1:0] limit;

    assign limit   = out_reg ? dly.off_delay : dly.on_delay;
    assign dly.out = out_reg;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= '0;
            out_reg   <= 1'b0;
        end else if (dly.cond == out_reg) begin
            count_reg <= '0;
        end else if (count_reg >= limit) begin
            out_reg   <= dly.cond;
            count_reg <= '0;
        end else if (sec_tick) begin
            count_reg <= count_reg + 10'h001;
        end
    end
endmodule

// *** alarm_evaluator.sv ***
// Alarm evaluator: three alarm channels with type select, hysteresis,
// standby sequence and ON/OFF delays, plus analog input scaling.
// Assumes measurement inputs and heater flags come from logic on mclk.
// Function
// - Each channel picks one of 19 types; upper deviation after reset.
// - ON and OFF delays of 0 to 999 seconds gate output changes.
// - Type 1 alarms when reading lies outside target minus lower to plus upper.
// - Type 2 alarms when reading exceeds target by trip amount or more.
// - Type 3 alarms when reading falls below target by trip amount or more.
// - Type 4 alarms when reading lies inside the band around target.
// - Types 5, 6, 7 are types 1, 2, 3 with standby suppression.
// - Type 8 alarms when reading is above the trip point.
// - Type 9 alarms when reading is below the trip point.
// - Types 10, 11 are types 8, 9 with standby suppression.
// - Type 14 alarms when target point is above the trip point.
// - Type 15 alarms when target point is below the trip point.
// - Types 16, 17 compare drive output above or below the trip point.
// - Types 18, 19 compare remote target above or below the trip point.
// - Band types hold separate upper and lower bounds per channel.
// - Type 5 stays off while upper and lower hysteresis regions overlap.
// - Heating/cooling: drive upper uses heating, drive lower uses cooling output.
// - Remote target types work only with CTRL_REMOTE set; in local mode they stay off.
// - Heater option with CTRL_CH1_ALARM clear routes channel 1 to heater fault, hides its type.
// - Analog input scales into -1999 to 9999; decimal point bits are only stored in ctrl_reg.
// - Hysteresis 0.1 to 999.9 degrees; alarms clear past the hysteresis.
`timescale 1ns/10ps
module alarm_evaluator #(
    parameter int SEC_DIV = alarm_pkg::SEC_CYCLES
) (
    input  wire logic                              mclk,
    input  wire logic                              rst_b,
    input  wire logic [alarm_pkg::AW-1:0]          reg_addr,
    input  wire logic [alarm_pkg::DW-1:0]          reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [alarm_pkg::DW-1:0]          reg_rdata,
    input  wire logic                              sample_valid,
    input  wire logic signed [alarm_pkg::VW-1:0]   temp_reading,
    input  wire logic [alarm_pkg::RAW_W-1:0]       analog_raw,
    input  wire logic signed [alarm_pkg::VW-1:0]   target_point,
    input  wire logic signed [alarm_pkg::VW-1:0]   remote_target,
    input  wire logic signed [alarm_pkg::VW-1:0]   drive_heat,
    input  wire logic signed [alarm_pkg::VW-1:0]   drive_cool,
    input  wire logic                              heater_burnout_flag,
    input  wire logic                              switch_failure_flag,
    output logic signed [alarm_pkg::VW-1:0]        process_reading,
    output logic      [alarm_pkg::NCH-1:0]         alarm_out,
    output logic                                   heater_fault_flag
);
    import alarm_pkg::*;

    logic [CTRL_W-1:0]      ctrl_reg;
    logic signed [VW-1:0]   scale_lo_reg;
    logic signed [VW-1:0]   scale_hi_reg;
    logic [TW-1:0]          type_reg     [NCH];
    logic signed [VW-1:0]   trip_reg     [NCH];
    logic signed [VW-1:0]   upper_reg    [NCH];
    logic signed [VW-1:0]   lower_reg    [NCH];
    logic [VW-1:0]          hys_reg      [NCH];
    logic [DLW-1:0]         on_dly_reg   [NCH];
    logic [DLW-1:0]         off_dly_reg  [NCH];
    logic [NCH-1:0]         raw_reg;
    logic [NCH-1:0]         raw_next;
    logic [NCH-1:0]         sby_done_reg;
    logic [NCH-1:0]         gated;
    logic [NCH-1:0]         type_wr;
    logic [NCH-1:0]         timer_out;
    logic signed [VW-1:0]   sp_prev_reg;
    logic [CNT_W-1:0]       sec_cnt_reg;
    logic                   sec_tick;
    logic [DW-1:0]          rdata_reg;
    logic [DW-1:0]          rd_value;
    logic                   htr_route;
    logic signed [VW-1:0]   pv_next;
    logic signed [31:0]     scale_prod;

    // Clamp a signed value into a span
    function automatic logic signed [VW-1:0] clamp_s(input logic signed [VW-1:0] v,
                                                     input logic signed [VW-1:0] lo,
                                                     input logic signed [VW-1:0] hi);
        clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Clamp an unsigned value into a span
    function automatic logic [VW-1:0] clamp_u(input logic [VW-1:0] v,
                                              input logic [VW-1:0] lo,
                                              input logic [VW-1:0] hi);
        clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic signed [XW-1:0] ext(input logic signed [VW-1:0] v);
        ext = XW'(v);
    endfunction

    // Upper compare with release hysteresis
    function automatic logic above(input logic signed [XW-1:0] x,
                                   input logic signed [XW-1:0] thr,
                                   input logic signed [XW-1:0] hys,
                                   input logic                 prev,
                                   input logic                 incl);
        if (prev)
            above = x > (thr - hys);
        else
            above = incl ? (x >= thr) : (x > thr);
    endfunction

    // Lower compare with release hysteresis
    function automatic logic below(input logic signed [XW-1:0] x,
                                   input logic signed [XW-1:0] thr,
                                   input logic signed [XW-1:0] hys,
                                   input logic                 prev,
                                   input logic                 incl);
        if (prev)
            below = x < (thr + hys);
        else
            below = incl ? (x <= thr) : (x < thr);
    endfunction

    function automatic logic is_standby(input logic [TW-1:0] t);
        is_standby = (t == AT_SB_BAND) || (t == AT_SB_HI) || (t == AT_SB_LO) ||
                     (t == AT_SB_ABS_HI) || (t == AT_SB_ABS_LO);
    endfunction

    // Raw alarm condition for one channel
    function automatic logic eval_cond(input logic [TW-1:0]       t,
                                       input logic signed [XW-1:0] pv,
                                       input logic signed [XW-1:0] sp,
                                       input logic signed [XW-1:0] trip,
                                       input logic signed [XW-1:0] up,
                                       input logic signed [XW-1:0] lo,
                                       input logic signed [XW-1:0] hys,
                                       input logic                 prev);
        logic signed [XW-1:0] rsp;
        logic signed [XW-1:0] mvh;
        logic signed [XW-1:0] mvl;
        logic                 out_band;
        rsp = ext(remote_target);
        mvh = ext(drive_heat);
        mvl = ctrl_reg[CTRL_HEATCOOL] ? ext(drive_cool) : ext(drive_heat);
        out_band = above(pv, sp + up, hys, prev, 1'b1) || below(pv, sp - lo, hys, prev, 1'b1);
        case (t)
            AT_DEV_BAND:              eval_cond = out_band;
            AT_SB_BAND:               eval_cond = ((up + lo) > (hys + hys)) && out_band;
            AT_DEV_HI, AT_SB_HI:      eval_cond = above(pv, sp + trip, hys, prev, 1'b1);
            AT_DEV_LO, AT_SB_LO:      eval_cond = below(pv, sp - trip, hys, prev, 1'b1);
            AT_RANGE:                 eval_cond = prev ? ((pv < sp + up + hys) && (pv > sp - lo - hys))
                                                       : ((pv < sp + up) && (pv > sp - lo));
            AT_ABS_HI, AT_SB_ABS_HI:  eval_cond = above(pv, trip, hys, prev, 1'b0);
            AT_ABS_LO, AT_SB_ABS_LO:  eval_cond = below(pv, trip, hys, prev, 1'b0);
            AT_SP_HI:                 eval_cond = above(sp, trip, hys, prev, 1'b0);
            AT_SP_LO:                 eval_cond = below(sp, trip, hys, prev, 1'b0);
            AT_MV_HI:                 eval_cond = above(mvh, trip, hys, prev, 1'b0);
            AT_MV_LO:                 eval_cond = below(mvl, trip, hys, prev, 1'b0);
            AT_RSP_HI:                eval_cond = ctrl_reg[CTRL_REMOTE] && above(rsp, trip, hys, prev, 1'b0);
            AT_RSP_LO:                eval_cond = ctrl_reg[CTRL_REMOTE] && below(rsp, trip, hys, prev, 1'b0);
            // none and unsupported types stay off
            default:                  eval_cond = 1'b0;
        endcase
    endfunction

    // Seconds tick divider
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            sec_cnt_reg <= '0;
        else if (sec_cnt_reg >= CNT_W'(SEC_DIV - 1))
            sec_cnt_reg <= '0;
        else
            sec_cnt_reg <= sec_cnt_reg + 25'h0000001;
    end
    assign sec_tick = (sec_cnt_reg >= CNT_W'(SEC_DIV - 1));

    always_comb begin
        scale_prod = 32'(ext(scale_hi_reg) - ext(scale_lo_reg)) * $signed({20'h00000, analog_raw});
        pv_next    = ctrl_reg[CTRL_ANALOG] ? VW'(ext(scale_lo_reg) + XW'(scale_prod >>> RAW_SHIFT))
                                           : temp_reading;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            process_reading <= '0;
            sp_prev_reg     <= '0;
        end else if (sample_valid) begin
            process_reading <= pv_next;
            sp_prev_reg     <= target_point;
        end
    end

    // Per-channel raw conditions
    always_comb begin
        for (int i = 0; i < NCH; i++)
            raw_next[i] = eval_cond(type_reg[i], ext(process_reading), ext(target_point),
                                    ext(trip_reg[i]), ext(upper_reg[i]), ext(lower_reg[i]),
                                    ext(signed'(hys_reg[i])), raw_reg[i]);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            raw_reg <= '0;
        else if (sample_valid)
            raw_reg <= raw_next;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sby_done_reg <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (sample_valid && !raw_next[i])
                    sby_done_reg[i] <= 1'b1;
                else if (type_wr[i] || (sample_valid && target_point != sp_prev_reg))
                    sby_done_reg[i] <= 1'b0;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++)
            gated[i] = raw_reg[i] && (!is_standby(type_reg[i]) || sby_done_reg[i]);
    end

    alarm_delay_if dly_if [NCH] ();

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        assign dly_if[g].cond      = gated[g];
        assign dly_if[g].on_delay  = on_dly_reg[g];
        assign dly_if[g].off_delay = off_dly_reg[g];
        assign timer_out[g]        = dly_if[g].out;
        alarm_delay_timer u_timer (
            .mclk     (mclk),
            .rst_b    (rst_b),
            .sec_tick (sec_tick),
            .dly      (dly_if[g])
        );
    end

    assign htr_route = ctrl_reg[CTRL_HTR_OPT] && !ctrl_reg[CTRL_CH1_ALARM];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_out         <= '0;
            heater_fault_flag <= 1'b0;
        end else begin
            heater_fault_flag <= ctrl_reg[CTRL_HTR_OPT] && (heater_burnout_flag || switch_failure_flag);
            alarm_out         <= timer_out;
            if (htr_route)
                alarm_out[0] <= heater_burnout_flag || switch_failure_flag;
        end
    end

    // Global register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg     <= CTRL_RST;
            scale_lo_reg <= SCALE_LO_RST;
            scale_hi_reg <= SCALE_HI_RST;
        end else if (reg_wr) begin
            if (reg_addr == CTRL_OFS)
                ctrl_reg <= reg_wdata[CTRL_W-1:0];
            if (reg_addr == SCALE_LO_OFS)
                scale_lo_reg <= clamp_s(reg_wdata[VW-1:0], SPAN_MIN, SPAN_MAX);
            if (reg_addr == SCALE_HI_OFS)
                scale_hi_reg <= clamp_s(reg_wdata[VW-1:0], SPAN_MIN, SPAN_MAX);
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++)
            type_wr[i] = reg_wr && (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_TYPE_OFS));
    end

    // Channel register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NCH; i++) begin
                type_reg[i]    <= TYPE_RST;
                trip_reg[i]    <= '0;
                upper_reg[i]   <= '0;
                lower_reg[i]   <= '0;
                hys_reg[i]     <= HYS_RST;
                on_dly_reg[i]  <= '0;
                off_dly_reg[i] <= '0;
            end
        end else if (reg_wr) begin
            for (int i = 0; i < NCH; i++) begin
                if (type_wr[i] && reg_wdata <= DW'(TYPE_LAST))
                    type_reg[i] <= reg_wdata[TW-1:0];
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_TRIP_OFS))
                    trip_reg[i] <= reg_wdata[VW-1:0];
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_UPPER_OFS))
                    upper_reg[i] <= reg_wdata[VW-1:0];
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_LOWER_OFS))
                    lower_reg[i] <= reg_wdata[VW-1:0];
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_HYS_OFS))
                    hys_reg[i] <= clamp_u(reg_wdata[VW-1:0], HYS_MIN, HYS_MAX);
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_ON_DLY_OFS))
                    on_dly_reg[i] <= (reg_wdata > DW'(DLY_MAX)) ? DLY_MAX : reg_wdata[DLW-1:0];
                if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_OFF_DLY_OFS))
                    off_dly_reg[i] <= (reg_wdata > DW'(DLY_MAX)) ? DLY_MAX : reg_wdata[DLW-1:0];
            end
        end
    end

    // Read decode
    always_comb begin
        rd_value = '0;
        unique case (reg_addr)
            CTRL_OFS:     rd_value = DW'(ctrl_reg);
            STATUS_OFS:   rd_value = DW'({heater_fault_flag, sby_done_reg, raw_reg, alarm_out});
            SCALE_LO_OFS: rd_value = DW'(unsigned'(scale_lo_reg));
            SCALE_HI_OFS: rd_value = DW'(unsigned'(scale_hi_reg));
            default:      rd_value = '0;
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_TYPE_OFS))
                rd_value = (i == 0 && htr_route) ? '0 : DW'(type_reg[i]);
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_TRIP_OFS))
                rd_value = DW'(unsigned'(trip_reg[i]));
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_UPPER_OFS))
                rd_value = DW'(unsigned'(upper_reg[i]));
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_LOWER_OFS))
                rd_value = DW'(unsigned'(lower_reg[i]));
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_HYS_OFS))
                rd_value = DW'(hys_reg[i]);
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_ON_DLY_OFS))
                rd_value = DW'(on_dly_reg[i]);
            if (reg_addr == CH_BASE_OFS + 8'(i) * CH_STRIDE + 8'(CH_OFF_DLY_OFS))
                rd_value = DW'(off_dly_reg[i]);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            rdata_reg <= '0;
        else
            rdata_reg <= reg_rd ? rd_value : '0;
    end
    assign reg_rdata = rdata_reg;
endmodule

// *** meas_path_model.sv ***
// Measurement path model: one sample pulse every 8 clocks.
// Assumes the bench sets the reading on pv_in.
`timescale 1ns/10ps
module meas_path_model (
    input wire logic               mclk,
    input wire logic               rst_b,
    input wire logic signed [15:0] pv_in,
    output logic                   sv,
    output logic signed [15:0]     pv
);
    logic [2:0] cnt_reg;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) cnt_reg <= 3'h0;
        else cnt_reg <= cnt_reg + 3'h1;
    end
    assign sv = rst_b && cnt_reg == 3'h7;
    assign pv = pv_in;
endmodule

// *** alarm_evaluator_checker.sv ***
// Port checker for the alarm evaluator.
// Assumes a bind to alarm_evaluator.
`timescale 1ns/10ps
module alarm_checker
    import alarm_pkg::*;
(
    input wire logic mclk, rst_b, reg_wr, reg_rd, sample_valid,
    input wire logic heater_burnout_flag, switch_failure_flag, heater_fault_flag,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata, reg_rdata,
    input wire logic signed [VW-1:0] temp_reading, process_reading,
    input wire logic [NCH-1:0] alarm_out
);
    logic [CTRL_W-1:0] ctrl_reg;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) ctrl_reg <= CTRL_RST;
        else if (reg_wr && reg_addr == CTRL_OFS) ctrl_reg <= reg_wdata[CTRL_W-1:0];
    end
    sequence rd_at(logic [AW-1:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("rdata");
    a_unmapped_zero: assert property (rd_at(8'h10) |=> reg_rdata == '0)
        else $error("unmapped");
    a_ctrl_readback: assert property (rd_at(CTRL_OFS) |=> reg_rdata[6:0] == $past(ctrl_reg))
        else $error("ctrl");
    a_status_out: assert property (rd_at(STATUS_OFS) |=> reg_rdata[2:0] == $past(alarm_out))
        else $error("status");
    a_pv_latch: assert property (sample_valid && !ctrl_reg[CTRL_ANALOG] |=>
        process_reading == $past(temp_reading)) else $error("latch");
    a_pv_hold: assert property (!sample_valid |=> $stable(process_reading))
        else $error("hold");
    a_fault_follow: assert property (1'b1 |=> heater_fault_flag ==
        $past(ctrl_reg[CTRL_HTR_OPT] && (heater_burnout_flag || switch_failure_flag))) else $error("fault");
    a_span_clamp: assert property (sample_valid && ctrl_reg[CTRL_ANALOG] |=>
        process_reading >= SPAN_MIN && process_reading <= SPAN_MAX) else $error("span");
endmodule
bind alarm_evaluator alarm_checker alarm_checker_i (.mclk, .rst_b, .reg_wr, .reg_rd, .sample_valid,
    .heater_burnout_flag, .switch_failure_flag, .heater_fault_flag, .reg_addr, .reg_wdata,
    .reg_rdata, .temp_reading, .process_reading, .alarm_out);

// *** test_alarm_evaluator.sv ***
// Bench for the alarm evaluator: channel 0 types and heater routing.
// Assumes the measurement model gives one sample per 8 clocks.
`timescale 1ns/10ps
module test_alarm_evaluator;
    logic mclk = 0, rst_b = 0, wr_s = 0, rd_s = 0, hb = 0, sv, hf;
    logic [7:0] adr = 0;
    logic [31:0] wd = 0, rdat;
    logic signed [15:0] pv = 0, tp = 0, dh = 0, pr, tr;
    logic [2:0] ao;
    int err_count = 0, n_tests = 0, cyc = 0;
    always #25 mclk = ~mclk;
    meas_path_model meas_path_model_i (.mclk, .rst_b, .pv_in(pv), .sv, .pv(tr));
    alarm_evaluator #(.SEC_DIV(4)) alarm_evaluator_i (.mclk, .rst_b, .reg_addr(adr), .reg_wdata(wd),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat), .sample_valid(sv), .temp_reading(tr),
        .analog_raw(12'h800), .target_point(tp), .remote_target(16'h0000), .drive_heat(dh),
        .drive_cool(16'h0000), .heater_burnout_flag(hb), .switch_failure_flag(1'b0),
        .process_reading(pr), .alarm_out(ao), .heater_fault_flag(hf));
    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        wr_s <= 1;
        adr <= a;
        wd <= d;
        @(posedge mclk);
        wr_s <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, m);
        @(posedge mclk);
        rd_s <= 1;
        adr <= a;
        @(posedge mclk);
        rd_s <= 0;
        #1 chk("rdata", e, rdat & m);
    endtask
    task automatic al(logic [4:0] ty, logic [15:0] trip, logic [15:0] v, logic e);
        wr(8'h20, 32'(ty));
        wr(8'h24, 32'(trip));
        pv <= v;
        repeat (40) @(posedge mclk);
        chk("alarm", 32'(e), 32'(ao[0]));
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1;
        rd(8'h20, 32'h2, '1);
        rd(8'h30, 32'h1, '1);
        rd(8'h10, 32'h0, '1);
        for (int t = 0; t < 21; t++) begin
            wr(8'h20, 32'(t));
            rd(8'h20, (t > 19) ? 32'h13 : 32'(t), '1);
        end
        wr(8'h28, 32'h0a);
        wr(8'h2c, 32'h0a);
        tp <= 16'h0064;
        dh <= 16'h012c;
        wr(8'h34, 32'h3e8);
        rd(8'h34, 32'h3e7, '1);
        al(5'h08, 16'h0064, 16'h00c8, 1'b0);
        wr(8'h34, 32'h0);
        al(5'h08, 16'h0064, 16'h00c8, 1'b1);
        chk("alarm12", 32'h3, 32'(ao[2:1]));
        al(5'h08, 16'h0064, 16'h0032, 1'b0);
        al(5'h02, 16'h0014, 16'h0078, 1'b1);
        al(5'h06, 16'h0014, 16'h0078, 1'b0);
        al(5'h06, 16'h0014, 16'h006e, 1'b0);
        al(5'h06, 16'h0014, 16'h0078, 1'b1);
        al(5'h02, 16'h0014, 16'h006e, 1'b0);
        al(5'h03, 16'h0014, 16'h0046, 1'b1);
        al(5'h01, 16'h0000, 16'h0073, 1'b1);
        al(5'h01, 16'h0000, 16'h0064, 1'b0);
        al(5'h04, 16'h0000, 16'h0064, 1'b1);
        al(5'h09, 16'h0032, 16'h0028, 1'b1);
        al(5'h0e, 16'h0032, 16'h0028, 1'b1);
        al(5'h0f, 16'h0032, 16'h0028, 1'b0);
        al(5'h10, 16'h00c8, 16'h0028, 1'b1);
        al(5'h12, 16'hff9c, 16'h0028, 1'b0);
        wr(8'h00, 32'h03);
        al(5'h11, 16'h0064, 16'h0028, 1'b1);
        al(5'h13, 16'h0064, 16'h0028, 1'b1);
        al(5'h00, 16'h0000, 16'h01f4, 1'b0);
        al(5'h05, 16'h0000, 16'h0064, 1'b0);
        al(5'h05, 16'h0000, 16'h01f4, 1'b1);
        wr(8'h30, 32'h0a);
        al(5'h05, 16'h0000, 16'h0064, 1'b0);
        al(5'h05, 16'h0000, 16'h01f4, 1'b0);
        hb <= 1;
        wr(8'h00, 32'h14);
        repeat (40) @(posedge mclk);
        chk("fault", 32'h1, 32'(hf));
        chk("alarm", 32'h1, 32'(ao[0]));
        chk("pv", 32'h32, 32'(pr));
        rd(8'h04, 32'h201, 32'h201);
        rd(8'h20, 32'h0, '1);
        wrap_up();
    end
endmodule
